//--- design/gas_alarm_supervisor.sv
// genset alarm supervisor: timed protections, engine-unit conditions, regs
//
// Contract
// - engine-unit message timeout raises comm loss, type-gated
// - speed below threshold for delay; zero delay off
// - no speed check stopped/starting/idle, before speed ok
// - manual, breaker open: needs option bit 2
// - speed check only in manual/auto/test/remote
// - differential current above threshold for delay
// - differential source: fourth CT or toroid
// - positive reactive power above threshold for delay
// - engine-unit conditions pass through enable mask
// - charger failure bit 11, held after start
// - maximum speed warning enabled by bit 10
// - high coolant temperature warning, bit 4
// - maximum coolant temperature alarm, bit 5
// - minimum coolant level alarm, bit 7
// - low coolant level warning, bit 6
// - low battery voltage warning, bit 9
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// condition-held delay timer counting time-base ticks
module gas_delay_timer (
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   input  wire logic        i_cond,
   input  wire logic        i_tick,
   input  wire logic [15:0] i_dly,
   output logic             o_trip
);
   typedef struct packed {
      logic [15:0] cnt;
   } gas_tmr_t;

   gas_tmr_t st;
   gas_tmr_t nxt;

   // count while held, restart on any drop
   always_comb begin
      nxt = st;
      if (!i_cond) begin
         nxt.cnt = 16'h0000;
      end else if (i_tick && st.cnt != 16'hFFFF) begin
         nxt.cnt = st.cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         st <= '0;
      end else begin
         st <= nxt;
      end
   end

   // zero delay disables the protection
   assign o_trip = i_cond && (i_dly != 16'h0000) && (st.cnt >= i_dly);
endmodule

module gas_alarm_supervisor #(
   parameter int P_TICK_CYCLES = gas_pkg::TICK_CYCLES
) (
   input  wire logic               i_mclk,
   input  wire logic               i_rstn,
   input  wire logic [5:0]         i_avs_address,
   input  wire logic               i_avs_read,
   input  wire logic               i_avs_write,
   input  wire logic [31:0]        i_avs_writedata,
   input  wire logic [3:0]         i_avs_byteenable,
   output logic      [31:0]        o_avs_readdata,
   output logic                    o_avs_waitrequest,
   input  wire gas_pkg::gas_meas_t i_meas,
   input  wire gas_pkg::gas_plant_t i_plant,
   input  wire logic               i_ecu_msg,
   input  wire logic [15:0]        i_ecu_flags,
   output logic                    o_engine_unit_comm_loss,
   output logic                    o_min_speed_protection,
   output logic                    o_diff_current_protection,
   output logic                    o_export_var_protection,
   output logic      [15:0]        o_can_alarms,
   output logic      [15:0]        o_can_warnings,
   output logic                    o_irq
);
   typedef struct packed {
      logic [gas_pkg::CFG_N-1:0][15:0] cfg;
      logic [gas_pkg::EV_N-1:0]        status;
      logic [gas_pkg::EV_N-1:0]        irq_mask;
      logic [3:0]                      prot;
      logic [15:0]                     can_alarm;
      logic [15:0]                     can_warn;
      logic                            speed_seen;
      logic                            was_starting;
      logic [15:0]                     chg_cnt;
      logic [9:0]                      sec_div;
      logic [15:0]                     ms_div;
      logic                            ack;
      logic [31:0]                     rdata;
      logic                            irq;
   } gas_state_t;

   localparam gas_state_t ST_RST = '{cfg: gas_pkg::CFG_RST, default: '0};
   localparam logic [15:0] TICK_LAST = 16'(P_TICK_CYCLES - 1);

   gas_state_t st;
   gas_state_t nxt;

   logic        tick;
   logic        eng_inactive;
   logic        comm_cond;
   logic        min_cond;
   logic        diff_cond;
   logic        var_cond;
   logic        chg_hold;
   logic [15:0] diff_val;
   logic        diff_sel_ct4;
   logic        diff_sel_tor;
   logic [3:0]  trip;
   logic [15:0] can_gate;
   logic [15:0] can_on;
   logic        req;
   logic        acc;
   logic [3:0]  idx;
   logic [15:0] wmask;
   logic [15:0] wval;

   // millisecond time base from the system clock
   assign tick = (st.ms_div == TICK_LAST);

   // engine not producing: stopped, stopping or starting
   assign eng_inactive = (i_plant.eng == gas_pkg::ENG_STOPPED) ||
                         (i_plant.eng == gas_pkg::ENG_STOPPING) ||
                         (i_plant.eng == gas_pkg::ENG_STARTING);

   // engine-unit silence, only with an engine type configured
   assign comm_cond = (st.cfg[gas_pkg::REG_ENGINE_TYPE] != 16'h0000) &&
                      !i_ecu_msg;

   // minimum speed supervision gates
   assign min_cond = i_plant.speed_acquired &&
                     (i_plant.mode != gas_pkg::MODE_OFF) &&
                     (i_plant.eng == gas_pkg::ENG_RUNNING) &&
                     st.speed_seen &&
                     !((i_plant.mode == gas_pkg::MODE_MANUAL) &&
                       !i_plant.generator_breaker &&
                       !st.cfg[gas_pkg::REG_OPTIONS]
                              [gas_pkg::OPT_MAN_OPEN_BIT]) &&
                     (i_meas.speed <
                      st.cfg[gas_pkg::REG_MINSPD_THR]);

   // differential current source selection
   assign diff_sel_ct4 = (st.cfg[gas_pkg::REG_CUR_USAGE]
                          [gas_pkg::CT4_USAGE_LSB +: 4] ==
                          gas_pkg::CT4_USAGE_DIFF);
   assign diff_sel_tor = (st.cfg[gas_pkg::REG_CUR_USAGE]
                          [gas_pkg::TOR_USAGE_LSB +: 4] ==
                          gas_pkg::TOR_USAGE_DIFF);
   assign diff_val = diff_sel_ct4 ? i_meas.diff_ct4 : i_meas.diff_toroid;
   assign diff_cond = i_plant.current_acquired &&
                      (diff_sel_ct4 || diff_sel_tor) &&
                      (diff_val > st.cfg[gas_pkg::REG_DIFF_THR]);

   // exported reactive power: positive and above threshold
   assign var_cond = i_plant.current_acquired && !eng_inactive &&
                     (i_plant.mode != gas_pkg::MODE_OFF) &&
                     ($signed(i_meas.var_q) > $signed(16'h0000)) &&
                     (i_meas.var_q >
                      st.cfg[gas_pkg::REG_VAR_THR]);

   gas_delay_timer u_comm (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_cond (comm_cond),
      .i_tick (tick),
      .i_dly  (st.cfg[gas_pkg::REG_COMM_TMO]),
      .o_trip (trip[gas_pkg::EV_COMM])
   );

   gas_delay_timer u_minspd (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_cond (min_cond),
      .i_tick (tick),
      .i_dly  (st.cfg[gas_pkg::REG_MINSPD_DLY]),
      .o_trip (trip[gas_pkg::EV_MINSPD])
   );

   gas_delay_timer u_diff (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_cond (diff_cond),
      .i_tick (tick),
      .i_dly  (st.cfg[gas_pkg::REG_DIFF_DLY]),
      .o_trip (trip[gas_pkg::EV_DIFF])
   );

   gas_delay_timer u_var (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_cond (var_cond),
      .i_tick (tick),
      .i_dly  (st.cfg[gas_pkg::REG_VAR_DLY]),
      .o_trip (trip[gas_pkg::EV_VAR])
   );

   // charger failure hold after start
   assign chg_hold = eng_inactive || (st.chg_cnt != 16'h0000);

   // enable mask per reported condition
   always_comb begin
      can_gate = st.cfg[gas_pkg::REG_CAN_MASK];
      if (chg_hold) begin
         can_gate[gas_pkg::CAN_BIT_CHARGER_FAIL] = 1'b0;
      end
   end
   assign can_on = i_ecu_flags & can_gate;

   // bus decode
   assign req   = i_avs_read || i_avs_write;
   assign acc   = req && st.ack;
   assign idx   = i_avs_address[5:2];
   assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wval  = i_avs_writedata[15:0];

   // next state of the whole block
   always_comb begin
      nxt = st;
      nxt.ms_div = tick ? 16'h0000 : st.ms_div + 16'h0001;
      // protection levels and class split
      nxt.prot = trip;
      nxt.can_alarm = can_on & gas_pkg::CAN_ALARM_CLASS;
      nxt.can_warn  = can_on & ~gas_pkg::CAN_ALARM_CLASS;
      // speed judged ok since the last start
      if ((i_plant.eng == gas_pkg::ENG_STOPPED) ||
          (i_plant.eng == gas_pkg::ENG_STARTING)) begin
         nxt.speed_seen = 1'b0;
      end else if ((i_plant.eng == gas_pkg::ENG_RUNNING) &&
                   i_plant.speed_ok) begin
         nxt.speed_seen = 1'b1;
      end
      // seconds of charger hold, loaded when starting ends
      nxt.was_starting = (i_plant.eng == gas_pkg::ENG_STARTING);
      if (st.was_starting && !nxt.was_starting) begin
         nxt.chg_cnt = st.cfg[gas_pkg::REG_CHG_HOLD];
         nxt.sec_div = 10'h000;
      end else if (tick) begin
         if (st.sec_div == gas_pkg::TICKS_PER_SEC - 10'h001) begin
            nxt.sec_div = 10'h000;
            if (st.chg_cnt != 16'h0000) begin
               nxt.chg_cnt = st.chg_cnt - 16'h0001;
            end
         end else begin
            nxt.sec_div = st.sec_div + 10'h001;
         end
      end
      // sticky events on rising protections, set beats clear
      if (acc && i_avs_write && i_avs_address[1:0] == 2'b00 &&
          idx == gas_pkg::REG_IRQ_STATUS) begin
         nxt.status = st.status & ~(wval[gas_pkg::EV_N-1:0] &
                                    wmask[gas_pkg::EV_N-1:0]);
      end
      nxt.status[3:0] = nxt.status[3:0] | (trip & ~st.prot);
      nxt.status[gas_pkg::EV_CAN_ALM] = nxt.status[gas_pkg::EV_CAN_ALM] |
         (|(nxt.can_alarm & ~st.can_alarm));
      nxt.status[gas_pkg::EV_CAN_WRN] = nxt.status[gas_pkg::EV_CAN_WRN] |
         (|(nxt.can_warn & ~st.can_warn));
      // register writes take effect at the accepting edge
      if (acc && i_avs_write && i_avs_address[1:0] == 2'b00) begin
         if (idx < 4'(gas_pkg::CFG_N)) begin
            nxt.cfg[idx] = (st.cfg[idx] & ~wmask) | (wval & wmask);
         end else if (idx == gas_pkg::REG_IRQ_MASK) begin
            nxt.irq_mask = (st.irq_mask & ~wmask[gas_pkg::EV_N-1:0]) |
                           (wval[gas_pkg::EV_N-1:0] &
                            wmask[gas_pkg::EV_N-1:0]);
         end
      end
      // one wait cycle, read data captured in it
      nxt.ack = req && !st.ack;
      if (req && !st.ack) begin
         nxt.rdata = 32'h0000_0000;
         if (i_avs_read && i_avs_address[1:0] == 2'b00) begin
            if (idx < 4'(gas_pkg::CFG_N)) begin
               nxt.rdata[15:0] = st.cfg[idx];
            end else if (idx == gas_pkg::REG_IRQ_STATUS) begin
               nxt.rdata[gas_pkg::EV_N-1:0] = st.status;
            end else if (idx == gas_pkg::REG_IRQ_MASK) begin
               nxt.rdata[gas_pkg::EV_N-1:0] = st.irq_mask;
            end else if (idx == gas_pkg::REG_LIVE) begin
               nxt.rdata[7:0] = {chg_hold, st.speed_seen,
                                 |st.can_warn, |st.can_alarm, st.prot};
            end
         end
      end
      nxt.irq = |(nxt.status & nxt.irq_mask);
   end

   // single state register of the block
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         st <= ST_RST;
      end else begin
         st <= nxt;
      end
   end

   // outputs straight from flip-flops, except waitrequest decoded from the request
   assign o_engine_unit_comm_loss   = st.prot[gas_pkg::EV_COMM];
   assign o_min_speed_protection    = st.prot[gas_pkg::EV_MINSPD];
   assign o_diff_current_protection = st.prot[gas_pkg::EV_DIFF];
   assign o_export_var_protection   = st.prot[gas_pkg::EV_VAR];
   assign o_can_alarms              = st.can_alarm;
   assign o_can_warnings            = st.can_warn;
   assign o_irq                     = st.irq;
   assign o_avs_readdata            = st.rdata;
   assign o_avs_waitrequest         = req && !st.ack;

   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   AST_COMM_TYPE0: assert property (
      st.cfg[gas_pkg::REG_ENGINE_TYPE] == 16'h0000 |=>
         !o_engine_unit_comm_loss)
      else $error("comm loss raised with no engine type");
   AST_COMM_MSG: assert property (
      i_ecu_msg |=> !o_engine_unit_comm_loss)
      else $error("comm loss raised despite message");
   AST_MIN_DLY0: assert property (
      st.cfg[gas_pkg::REG_MINSPD_DLY] == 16'h0000 |=>
         !o_min_speed_protection)
      else $error("min speed raised with zero delay");
   AST_MIN_ENGINE: assert property (
      (i_plant.eng != gas_pkg::ENG_RUNNING || !st.speed_seen) |=>
         !o_min_speed_protection)
      else $error("min speed raised while engine not judged running");
   AST_MIN_MANOPEN: assert property (
      (i_plant.mode == gas_pkg::MODE_MANUAL && !i_plant.generator_breaker
       && !st.cfg[gas_pkg::REG_OPTIONS][gas_pkg::OPT_MAN_OPEN_BIT]) |=>
         !o_min_speed_protection)
      else $error("min speed raised in manual with breaker open");
   AST_MIN_OFF: assert property (
      i_plant.mode == gas_pkg::MODE_OFF |=> !o_min_speed_protection)
      else $error("min speed raised in off mode");
   AST_DIFF_SRC: assert property (
      (!i_plant.current_acquired || !(diff_sel_ct4 || diff_sel_tor)) |=>
         !o_diff_current_protection)
      else $error("diff current raised with no source");
   AST_VAR_SIGN: assert property (
      ($signed(i_meas.var_q) <= $signed(16'h0000) || eng_inactive) |=>
         !o_export_var_protection)
      else $error("export var raised with non-positive power");
   AST_CAN_MASK: assert property (
      ##1 ((o_can_alarms | o_can_warnings) &
           ~$past(st.cfg[gas_pkg::REG_CAN_MASK])) == 16'h0000)
      else $error("masked condition reported");
   AST_CHG_HOLD: assert property (
      chg_hold |=> !o_can_warnings[gas_pkg::CAN_BIT_CHARGER_FAIL])
      else $error("charger failure during hold");
   AST_CAN_CLASS: assert property (
      i_ecu_flags[gas_pkg::CAN_BIT_MAX_COOLANT_T] &&
      can_gate[gas_pkg::CAN_BIT_MAX_COOLANT_T] |=>
         o_can_alarms[gas_pkg::CAN_BIT_MAX_COOLANT_T] &&
         !o_can_warnings[gas_pkg::CAN_BIT_MAX_COOLANT_T])
      else $error("coolant temperature not an alarm");
   AST_RESTART: assert property (
      !min_cond ##1 !min_cond |-> !trip[gas_pkg::EV_MINSPD] ##1
         !o_min_speed_protection)
      else $error("min speed timer kept running after drop");

   COV_MINSPD: cover property ($rose(o_min_speed_protection));
   COV_COMM:   cover property ($rose(o_engine_unit_comm_loss));
   COV_CHG:    cover property ($fell(chg_hold) ##1
                               o_can_warnings[gas_pkg::CAN_BIT_CHARGER_FAIL]);
   COV_IRQ:    cover property ($rose(o_irq));
endmodule

`default_nettype wire

//--- design/gas_pkg.sv
// shared constants and types of the genset alarm supervisor
package gas_pkg;

   // clock and protection time base
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
   localparam logic [9:0] TICKS_PER_SEC = 10'h3E8;

   // register word indices, byte address is four times the index
   localparam logic [3:0] REG_ENGINE_TYPE = 4'h0;
   localparam logic [3:0] REG_OPTIONS     = 4'h1;
   localparam logic [3:0] REG_CUR_USAGE   = 4'h2;
   localparam logic [3:0] REG_COMM_TMO    = 4'h3;
   localparam logic [3:0] REG_MINSPD_THR  = 4'h4;
   localparam logic [3:0] REG_MINSPD_DLY  = 4'h5;
   localparam logic [3:0] REG_DIFF_THR    = 4'h6;
   localparam logic [3:0] REG_DIFF_DLY    = 4'h7;
   localparam logic [3:0] REG_VAR_THR     = 4'h8;
   localparam logic [3:0] REG_VAR_DLY     = 4'h9;
   localparam logic [3:0] REG_CAN_MASK    = 4'hA;
   localparam logic [3:0] REG_CHG_HOLD    = 4'hB;
   localparam logic [3:0] REG_IRQ_STATUS  = 4'hC;
   localparam logic [3:0] REG_IRQ_MASK    = 4'hD;
   localparam logic [3:0] REG_LIVE        = 4'hE;
   localparam int         CFG_N           = 12;

   // configuration reset values, enable mask starts all ones
   localparam logic [CFG_N-1:0][15:0] CFG_RST = {16'h0000, 16'hFFFF,
                                                 160'h0};

   // field positions
   localparam int OPT_MAN_OPEN_BIT = 2;
   localparam int CT4_USAGE_LSB    = 0;
   localparam int TOR_USAGE_LSB    = 4;
   localparam logic [3:0] CT4_USAGE_DIFF = 4'h2;
   localparam logic [3:0] TOR_USAGE_DIFF = 4'h3;

   // enable mask bits of the engine-unit reported conditions
   localparam int CAN_BIT_HIGH_COOLANT_T = 4;
   localparam int CAN_BIT_MAX_COOLANT_T  = 5;
   localparam int CAN_BIT_LOW_COOLANT_L  = 6;
   localparam int CAN_BIT_MIN_COOLANT_L  = 7;
   localparam int CAN_BIT_LOW_BATTERY    = 9;
   localparam int CAN_BIT_MAX_SPEED      = 10;
   localparam int CAN_BIT_CHARGER_FAIL   = 11;
   // conditions of alarm class, all others are warnings
   localparam logic [15:0] CAN_ALARM_CLASS = 16'h00AA;

   // status and live bit positions
   localparam int EV_COMM     = 0;
   localparam int EV_MINSPD   = 1;
   localparam int EV_DIFF     = 2;
   localparam int EV_VAR      = 3;
   localparam int EV_CAN_ALM  = 4;
   localparam int EV_CAN_WRN  = 5;
   localparam int EV_N        = 6;

   typedef enum logic [2:0] {
      ENG_STOPPED, ENG_STOPPING, ENG_STARTING, ENG_IDLE_CYCLE, ENG_RUNNING
   } gas_eng_t;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_MANUAL, MODE_AUTO, MODE_TEST, MODE_REMOTE
   } gas_mode_t;

   // measured quantities
   typedef struct packed {
      logic [15:0] speed;
      logic [15:0] diff_ct4;
      logic [15:0] diff_toroid;
      logic [15:0] var_q;
   } gas_meas_t;

   // plant status
   typedef struct packed {
      gas_eng_t  eng;
      gas_mode_t mode;
      logic      generator_breaker;
      logic      speed_acquired;
      logic      speed_ok;
      logic      current_acquired;
   } gas_plant_t;

endpackage

//--- verification/gas_alarm_supervisor_test.sv
// self-checking bench of the genset alarm supervisor
`timescale 1ns/1ps
`default_nettype none
module gas_alarm_supervisor_test;
   localparam int TK = 10;
   logic                mclk = 1'b0;
   logic                rstn = 1'b0;
   logic [5:0]          addr = 6'h00;
   logic                rd = 1'b0;
   logic                wr = 1'b0;
   logic [31:0]         wdata = 32'h0;
   logic [31:0]         rdata;
   logic                wait_req;
   gas_pkg::gas_meas_t  meas = '0;
   gas_pkg::gas_plant_t plant = '0;
   logic [7:0]          period = 8'h14;
   logic [15:0]         flags = 16'h0000;
   logic                msg;
   logic [15:0]         eflags;
   logic [15:0]         alm;
   logic [15:0]         wrn;
   logic                comm;
   logic                mins;
   logic                diff;
   logic                var_p;
   logic                irq;
   int                  mismatches = 0;
   int                  total_checks = 0;
   logic [31:0]         q;
   logic [15:0]         m;

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   gas_ecu_model ecu_u (.i_mclk(mclk), .i_rstn(rstn), .i_period(period),
      .i_flags(flags), .o_msg(msg), .o_flags(eflags));

   gas_alarm_supervisor #(.P_TICK_CYCLES(TK)) dut_u (.i_mclk(mclk),
      .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'h3),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_meas(meas),
      .i_plant(plant), .i_ecu_msg(msg), .i_ecu_flags(eflags),
      .o_engine_unit_comm_loss(comm), .o_min_speed_protection(mins),
      .o_diff_current_protection(diff), .o_export_var_protection(var_p),
      .o_can_alarms(alm), .o_can_warnings(wrn), .o_irq(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] idx,
                      input logic [15:0] d);
      int n;
      @(posedge mclk);
      addr <= {idx, 2'b00};
      rd <= !w;
      wr <= w;
      wdata <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         mismatches++;
         print_verdict();
      end
   endtask

   task automatic rchk(input logic [3:0] idx, input logic [15:0] e);
      bus(1'b0, idx, 16'h0000);
      chk(q, {16'h0000, e});
   endtask

   // wait, then compare {comm, minspd, diff, var}
   task automatic step(input int n, input logic [3:0] e);
      repeat (n) @(posedge mclk);
      chk({28'h0, comm, mins, diff, var_p}, {28'h0, e});
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      mismatches++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      plant.speed_acquired <= 1'b1;
      plant.current_acquired <= 1'b1;
      rchk(gas_pkg::REG_CAN_MASK, 16'hFFFF);
      rchk(gas_pkg::REG_ENGINE_TYPE, 16'h0000);
      bus(1'b1, 4'hF, 16'h1234);
      rchk(4'hF, 16'h0000);
      // message supervision, gated by engine type, and its interrupt
      bus(1'b1, gas_pkg::REG_COMM_TMO, 16'h0005);
      period <= 8'h00;
      step(100, 4'h0);
      bus(1'b1, gas_pkg::REG_ENGINE_TYPE, 16'h0001);
      step(100, 4'h8);
      period <= 8'h14;
      step(100, 4'h0);
      period <= 8'h00;
      step(20, 4'h0);
      step(40, 4'h8);
      rchk(gas_pkg::REG_IRQ_STATUS, 16'h0001);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, gas_pkg::REG_IRQ_MASK, 16'h0001);
      period <= 8'h14;
      step(40, 4'h0);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, gas_pkg::REG_IRQ_STATUS, 16'h0001);
      rchk(gas_pkg::REG_IRQ_STATUS, 16'h0000);
      chk({31'h0, irq}, 32'h0);
      // engine-unit conditions through the enable mask
      plant.eng <= gas_pkg::ENG_RUNNING;
      flags <= 16'hFFFF;
      for (int i = 3; i < 12; i++) begin
         m = (i == 3) ? 16'hFFFF : ~(16'h0001 << i);
         bus(1'b1, gas_pkg::REG_CAN_MASK, m);
         repeat (3) @(posedge mclk);
         chk({16'h0, alm}, {16'h0, m & 16'h00AA});
         chk({16'h0, wrn}, {16'h0, m & 16'hFF55});
      end
      // charger warning held while stopped and after start
      bus(1'b1, gas_pkg::REG_CAN_MASK, 16'hFFFF);
      bus(1'b1, gas_pkg::REG_CHG_HOLD, 16'h0001);
      plant.eng <= gas_pkg::ENG_STOPPED;
      step(5, 4'h0);
      chk({31'h0, wrn[11]}, 32'h0);
      plant.eng <= gas_pkg::ENG_STARTING;
      step(5, 4'h0);
      plant.eng <= gas_pkg::ENG_RUNNING;
      plant.mode <= gas_pkg::MODE_AUTO;
      step(100, 4'h0);
      chk({31'h0, wrn[11]}, 32'h0);
      step(10000, 4'h0);
      chk({31'h0, wrn[11]}, 32'h1);
      // minimum speed, not before speed has been judged acceptable
      bus(1'b1, gas_pkg::REG_MINSPD_THR, 16'h0064);
      bus(1'b1, gas_pkg::REG_MINSPD_DLY, 16'h0003);
      meas.speed <= 16'h0032;
      step(60, 4'h0);
      plant.speed_ok <= 1'b1;
      step(12, 4'h0);
      plant.speed_ok <= 1'b0;
      step(48, 4'h4);
      plant.eng <= gas_pkg::ENG_IDLE_CYCLE;
      step(60, 4'h0);
      plant.eng <= gas_pkg::ENG_RUNNING;
      plant.generator_breaker <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         plant.mode <= gas_pkg::gas_mode_t'(i);
         step(60, (i == 0) ? 4'h0 : 4'h4);
      end
      plant.mode <= gas_pkg::MODE_MANUAL;
      plant.generator_breaker <= 1'b0;
      step(60, 4'h0);
      bus(1'b1, gas_pkg::REG_OPTIONS, 16'h0004);
      step(60, 4'h4);
      bus(1'b1, gas_pkg::REG_MINSPD_DLY, 16'h0000);
      step(60, 4'h0);
      meas.speed <= 16'h0096;
      bus(1'b1, gas_pkg::REG_MINSPD_DLY, 16'h0003);
      for (int i = 0; i < 8; i++) begin
         meas.speed <= i[0] ? 16'h0096 : 16'h0032;
         step(15, 4'h0);
      end
      // differential current from either source
      bus(1'b1, gas_pkg::REG_DIFF_THR, 16'h0064);
      bus(1'b1, gas_pkg::REG_DIFF_DLY, 16'h0002);
      bus(1'b1, gas_pkg::REG_CUR_USAGE, 16'h0002);
      meas.diff_ct4 <= 16'h00C8;
      step(60, 4'h2);
      bus(1'b1, gas_pkg::REG_CUR_USAGE, 16'h0030);
      meas.diff_ct4 <= 16'h0000;
      meas.diff_toroid <= 16'h00C8;
      step(60, 4'h2);
      plant.current_acquired <= 1'b0;
      step(60, 4'h0);
      plant.current_acquired <= 1'b1;
      bus(1'b1, gas_pkg::REG_CUR_USAGE, 16'h0000);
      step(60, 4'h0);
      bus(1'b1, gas_pkg::REG_CUR_USAGE, 16'h0030);
      bus(1'b1, gas_pkg::REG_DIFF_DLY, 16'h0000);
      step(60, 4'h0);
      // exported reactive power
      bus(1'b1, gas_pkg::REG_VAR_THR, 16'h0064);
      bus(1'b1, gas_pkg::REG_VAR_DLY, 16'h0002);
      meas.var_q <= 16'h00C8;
      step(60, 4'h1);
      rchk(gas_pkg::REG_LIVE, 16'h0078);
      meas.var_q <= 16'hFF38;
      step(60, 4'h0);
      meas.var_q <= 16'h00C8;
      plant.eng <= gas_pkg::ENG_STOPPING;
      step(60, 4'h0);
      print_verdict();
   end
endmodule
`default_nettype wire

//--- verification/gas_ecu_model.sv
// engine control unit model: periodic messages and reported conditions
`timescale 1ns/1ps
`default_nettype none
module gas_ecu_model (
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   input  wire logic [7:0]  i_period,
   input  wire logic [15:0] i_flags,
   output logic             o_msg,
   output logic      [15:0] o_flags
);
   logic [7:0] cnt_r;
   // one-cycle message pulse every i_period cycles, zero keeps it silent
   always_ff @(posedge i_mclk) begin
      if (!i_rstn || i_period == 8'h00) begin
         cnt_r <= 8'h00;
         o_msg <= 1'b0;
      end else begin
         o_msg <= (cnt_r == i_period - 8'h01);
         cnt_r <= (cnt_r == i_period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
      end
   end
   // reported conditions, paired bit for bit with the enable mask
   assign o_flags = i_flags;
endmodule
`default_nettype wire
